// ---- ccms_pkg.sv ----
// Shared constants, mode codes and helpers for the CPU clock mode selector
package ccms_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int REF_CLK_HZ = 25_000_000;
  // Free-running PLL rate, inside its 2 to 10 MHz band
  localparam int PLL_FREE_HZ = 5_000_000;
  // Reference cycles per free-running half period, rounded down
  localparam int PLL_FREE_HALF = (REF_CLK_HZ / (2 * PLL_FREE_HZ)) < 1 ? 1 : REF_CLK_HZ / (2 * PLL_FREE_HZ);
  localparam int FREE_W = 4;
  // Watchdog overflows after this many free-running PLL cycles
  localparam int WDOG_OVF = 16;
  localparam int WDOG_W = 4;
  localparam int PER_W = 16;
  localparam int TGL_W = 5;

  // ****************************************
  // Clock generation modes, coded as the strap pattern
  // ****************************************
  typedef enum logic [2:0] {
    MODE_X2P5 = 3'h0,
    MODE_PRESC = 3'h1,
    MODE_X10 = 3'h2,
    MODE_DIRECT = 3'h3,
    MODE_X5 = 3'h4,
    MODE_X2 = 3'h5,
    MODE_X3 = 3'h6,
    MODE_X4 = 3'h7
  } ccms_mode_t;

  localparam logic [2:0] MODE_RESET = 3'h7;

  typedef enum logic [1:0] {
    SRC_STRAP = 2'h0,
    SRC_PLL_FREE = 2'h1
  } ccms_src_t;

  typedef struct packed {
    logic cpu_clk;
    logic cpu_edge;
  } ccms_clk_t;

  // CPU clock edges per input period in the multiplying modes (2 x F)
  function automatic logic [TGL_W-1:0] ccms_toggles(input ccms_mode_t m);
    unique case (m)
      MODE_X4: ccms_toggles = 5'h08;
      MODE_X3: ccms_toggles = 5'h06;
      MODE_X2: ccms_toggles = 5'h04;
      MODE_X5: ccms_toggles = 5'h0a;
      MODE_X10: ccms_toggles = 5'h14;
      MODE_X2P5: ccms_toggles = 5'h05;
      MODE_PRESC, MODE_DIRECT: ccms_toggles = 5'h00;
    endcase
  endfunction

  function automatic logic ccms_bypass(input ccms_mode_t m);
    ccms_bypass = (m == MODE_DIRECT) || (m == MODE_PRESC);
  endfunction

endpackage

// ---- ccms_pll_nco.sv ----
// Digital model of the multiplying PLL: edge generator resynchronised to the input
module ccms_pll_nco #(
  parameter int PW = ccms_pkg::PER_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic in_rise,
  input wire logic [ccms_pkg::TGL_W-1:0] toggles,
  output logic tick
);
  import ccms_pkg::*;

  typedef struct packed {
    logic [PW-1:0] period_cnt;
    logic [PW-1:0] period;
    logic [PW:0] phase;
    logic tick;
  } ccms_nco_t;

  ccms_nco_t s;
  ccms_nco_t next_s;
  logic [PW:0] sum;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    sum = s.phase + {{(PW + 1 - TGL_W){1'b0}}, toggles};
    if (s.period_cnt != {PW{1'b1}}) begin
      next_s.period_cnt = s.period_cnt + 1'b1;
    end
    if (in_rise) begin
      next_s.period = s.period_cnt + 1'b1;
      next_s.period_cnt = '0;
      // The rise cycle is the first step of the new period, so 2F edges fit in it
      next_s.phase = {{(PW + 1 - TGL_W){1'b0}}, toggles};
    end else if (enable && s.period != '0) begin
      if (sum >= {1'b0, s.period}) begin
        next_s.tick = 1'b1;
        next_s.phase = sum - {1'b0, s.period};
      end else begin
        next_s.phase = sum;
      end
    end
    if (srst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign tick = s.tick;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_resync_phase: assert property (in_rise |=> s.phase == (PW + 1)'($past(toggles)) && !s.tick)
    else $error("phase not cleared on input rise");

endmodule

// ---- ccms_top.sv ----
// CPU clock mode selector: strap capture, PLL, prescaler, direct drive and watchdog
// Notes on behaviour
// - Both CPU clock edges are events, and the time between two edges is the half clock period.
// - The mode comes from the three clock mode pins while reset is held.
// - Straps 111, 110, 101, 100 give x4 (default), x3, x2 and x5.
// - Straps 011, 010, 001, 000 give direct x1, x10, prescaled x0.5 and x2.5.
// - In prescaler mode the CPU clock is the input divided by two.
// - In prescaler mode each CPU clock phase lasts exactly one input period.
// - In direct mode the PLL is not the source and the CPU clock is the input itself.
// - In direct mode the phases follow the input duty, two half periods making one input period.
// - In direct or prescaler mode the PLL free-runs for the watchdog unless disabled, then it is off.
// - In multiplying modes the PLL resynchronises to the input and never jumps.
// - The watchdog clears on each input transition and at sixteen PLL cycles switches to the PLL and flags.
// - After a switch-over the CPU clock stays on the free-running PLL until hardware reset.
// - In direct and prescaler modes the watchdog is on after reset and off while the disable bit is set; in multiplying modes it is off.
module ccms_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic osc_in,
  input wire logic [2:0] clock_mode_pins,
  input wire logic osc_watchdog_disable,
  output ccms_pkg::ccms_clk_t cpu_clock,
  output ccms_pkg::ccms_mode_t clock_mode,
  output logic pll_powered,
  output logic osc_failed,
  output logic osc_fail_irq
);
  import ccms_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_d;
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;
    ccms_mode_t mode;
    ccms_src_t src;
    logic cpu_clk;
    logic cpu_edge;
    logic [FREE_W-1:0] free_cnt;
    logic free_clk;
    logic [WDOG_W-1:0] wdog_cnt;
    logic pll_on;
    logic irq;
  } ccms_state_t;

  ccms_state_t s;
  ccms_state_t next_s;
  logic osc_rise;
  logic osc_tr;
  logic bypass;
  logic wd_on;
  logic free_rise;
  logic nco_tick;
  logic nco_en;

  assign osc_rise = s.osc_s2 && !s.osc_d;
  assign osc_tr = s.osc_s2 ^ s.osc_d;
  assign bypass = ccms_bypass(s.mode);
  assign wd_on = bypass && !osc_watchdog_disable;
  assign nco_en = !bypass && s.src == SRC_STRAP;

  ccms_pll_nco #(
    .PW(PER_W)
  ) u_nco (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(nco_en),
    .in_rise(osc_rise),
    .toggles(ccms_toggles(s.mode)),
    .tick(nco_tick)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.osc_s1 = osc_in;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_d = s.osc_s2;
    next_s.pins_s1 = clock_mode_pins;
    next_s.pins_s2 = s.pins_s1;
    next_s.irq = 1'b0;
    free_rise = 1'b0;
    next_s.pll_on = !bypass || wd_on || s.src == SRC_PLL_FREE;
    if (next_s.pll_on && (bypass || s.src == SRC_PLL_FREE)) begin
      if (s.free_cnt == FREE_W'(PLL_FREE_HALF - 1)) begin
        next_s.free_cnt = '0;
        next_s.free_clk = !s.free_clk;
        free_rise = !s.free_clk;
      end else begin
        next_s.free_cnt = s.free_cnt + 1'b1;
      end
    end
    if (wd_on && s.src == SRC_STRAP) begin
      if (osc_tr) begin
        next_s.wdog_cnt = '0;
      end else if (free_rise) begin
        if (s.wdog_cnt == WDOG_W'(WDOG_OVF - 1)) begin
          next_s.src = SRC_PLL_FREE;
          next_s.irq = 1'b1;
          next_s.wdog_cnt = '0;
        end else begin
          next_s.wdog_cnt = s.wdog_cnt + 1'b1;
        end
      end
    end
    if (s.src == SRC_PLL_FREE) begin
      next_s.cpu_clk = next_s.free_clk;
    end else if (s.mode == MODE_DIRECT) begin
      next_s.cpu_clk = s.osc_s2;
    end else if (s.mode == MODE_PRESC) begin
      if (osc_rise) begin
        next_s.cpu_clk = !s.cpu_clk;
      end
    end else if (nco_tick) begin
      next_s.cpu_clk = !s.cpu_clk;
    end
    next_s.cpu_edge = next_s.cpu_clk != s.cpu_clk;
    if (srst) begin
      next_s.mode = ccms_mode_t'(s.pins_s2);
      next_s.src = SRC_STRAP;
      next_s.cpu_clk = 1'b0;
      next_s.cpu_edge = 1'b0;
      next_s.free_cnt = '0;
      next_s.free_clk = 1'b0;
      next_s.wdog_cnt = '0;
      next_s.pll_on = 1'b0;
      next_s.irq = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cpu_clock.cpu_clk = s.cpu_clk;
  assign cpu_clock.cpu_edge = s.cpu_edge;
  assign clock_mode = s.mode;
  assign pll_powered = s.pll_on;
  assign osc_failed = s.src == SRC_PLL_FREE;
  assign osc_fail_irq = s.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence seq_wdog_last;
    wd_on && s.src == SRC_STRAP && !osc_tr && free_rise && s.wdog_cnt == WDOG_W'(WDOG_OVF - 1);
  endsequence

  sequence seq_failed;
    s.src == SRC_PLL_FREE && s.irq;
  endsequence

  sequence seq_switch_over;
    $rose(s.src == SRC_PLL_FREE);
  endsequence

  a_edge_mark: assert property ($changed(s.cpu_clk) |-> s.cpu_edge)
    else $error("cpu edge not marked");
  a_mode_capture: assert property ($fell(srst) |-> s.mode == $past(s.pins_s2))
    else $error("mode not taken from straps");
  a_mode_held: assert property (!$past(srst) |-> $stable(s.mode))
    else $error("mode changed outside reset");
  a_presc_toggle: assert property (s.mode == MODE_PRESC && s.src == SRC_STRAP && osc_rise
    |=> s.cpu_clk != $past(s.cpu_clk))
    else $error("prescaler missed input rise");
  a_presc_hold: assert property (s.mode == MODE_PRESC && s.src == SRC_STRAP && !osc_rise
    |=> $stable(s.cpu_clk))
    else $error("prescaler changed without input rise");
  a_direct_follow: assert property (s.mode == MODE_DIRECT && s.src == SRC_STRAP
    |=> s.cpu_clk == $past(s.osc_s2))
    else $error("direct clock not following input");
  a_pll_off: assert property (bypass && osc_watchdog_disable && s.src == SRC_STRAP |=> !s.pll_on)
    else $error("pll powered while disabled");
  a_wdog_ovf: assert property (seq_wdog_last |=> seq_failed)
    else $error("watchdog overflow did not switch");
  a_wdog_clear: assert property (wd_on && s.src == SRC_STRAP && osc_tr |=> s.wdog_cnt == '0)
    else $error("watchdog not cleared by input");
  a_fail_sticky: assert property (s.src == SRC_PLL_FREE |=> s.src == SRC_PLL_FREE && !s.irq)
    else $error("left free-running source");
  a_wdog_default: assert property ($fell(srst) && ccms_bypass(s.mode) && !osc_watchdog_disable
    |=> s.pll_on)
    else $error("watchdog not enabled after reset");
  a_irq_flag: assert property (seq_switch_over |-> s.irq)
    else $error("switch-over without failure flag");
  a_mult_pll_on: assert property (!bypass |=> s.pll_on)
    else $error("pll off in multiplying mode");
  a_wdog_idle: assert property (bypass && osc_watchdog_disable && s.src == SRC_STRAP
    |=> $stable(s.wdog_cnt) && !s.irq)
    else $error("watchdog ran while disabled");
  a_fail_clock: assert property (s.src == SRC_PLL_FREE |=> s.cpu_clk == s.free_clk)
    else $error("cpu clock not on free-running pll");
  a_edge_single: assert property (s.cpu_edge |-> $changed(s.cpu_clk))
    else $error("edge mark without clock change");

endmodule

// ---- ccms_osc_model.sv ----
// Oscillator source model driving the clock selector input pin
module ccms_osc_model (
  input wire logic run,
  input wire logic [15:0] hi_ns,
  input wire logic [15:0] lo_ns,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Waveform, phase kept off the sampling edge
  // ****************************************
  initial begin
    osc = 1'b0;
    #13;
    forever begin
      if (run) begin
        osc = 1'b1;
        #(hi_ns);
        osc = 1'b0;
        #(lo_ns);
      end else begin
        // A dead crystal stays at one level
        #40;
      end
    end
  end
endmodule

// ---- ccms_top_tb_top.sv ----
// Self-checking testbench for the CPU clock mode selector
module ccms_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccms_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] clock_mode_pins = 3'h7;
  logic osc_watchdog_disable = 1'b1;
  logic run = 1'b1;
  logic [15:0] hi_ns = 16'h0320;
  logic [15:0] lo_ns = 16'h0320;
  logic osc_in;
  ccms_clk_t cpu_clock;
  ccms_mode_t clock_mode;
  logic pll_powered, osc_failed, osc_fail_irq;
  int err_total = 0;
  int checked = 0;
  int edges = 0, irqs = 0, cyc = 0, last = 0, gap = 0, pgap = 0, e0;
  logic prev_clk = 1'b0;
  // Edges per four 40-cycle input periods, indexed by strap pattern
  logic [15:0] exp_edges [8] = '{16'h0014, 16'h0004, 16'h0050, 16'h0008,
                                 16'h0028, 16'h0010, 16'h0018, 16'h0020};

  ccms_osc_model osc_src (.run(run), .hi_ns(hi_ns), .lo_ns(lo_ns), .osc(osc_in));
  ccms_top uut (.ref_clk(ref_clk), .srst(srst), .osc_in(osc_in), .clock_mode_pins(clock_mode_pins),
    .osc_watchdog_disable(osc_watchdog_disable), .cpu_clock(cpu_clock), .clock_mode(clock_mode),
    .pll_powered(pll_powered), .osc_failed(osc_failed), .osc_fail_irq(osc_fail_irq));

  always #20 ref_clk = ~ref_clk;

  // ****************************************
  // Edge and pulse bookkeeping
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    if (srst === 1'b0) chk({15'h0000, cpu_clock.cpu_edge}, {15'h0000, cpu_clock.cpu_clk !== prev_clk});
    prev_clk = cpu_clock.cpu_clk;
    if (cpu_clock.cpu_edge === 1'b1) begin
      edges++;
      pgap = gap;
      gap = cyc - last;
      last = cyc;
    end
    if (osc_fail_irq === 1'b1) irqs++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic restart(input logic [2:0] pins, input logic dis);
    @(posedge ref_clk);
    clock_mode_pins <= pins;
    osc_watchdog_disable <= dis;
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic count(input int n, output logic [15:0] res);
    @(posedge ref_clk);
    #1;
    e0 = edges;
    repeat (n) @(posedge ref_clk);
    #1;
    res = 16'(edges - e0);
  endtask

  task automatic conclude();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge ref_clk);
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    conclude();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [15:0] n;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      restart(3'(i), 1'b1);
      chk(16'(clock_mode), 16'(i));
      @(posedge ref_clk);
      clock_mode_pins <= ~3'(i);
      repeat (119) @(posedge ref_clk);
      count(160, n);
      chk(n, exp_edges[i]);
      chk({15'h0000, pll_powered}, (i == 1 || i == 3) ? 16'h0000 : 16'h0001);
      chk(16'(clock_mode), 16'(i));
    end
    $display("test mode table done");
    hi_ns <= 16'h0078;
    lo_ns <= 16'h00c8;
    restart(3'h3, 1'b1);
    count(64, n);
    chk(16'(gap + pgap), 16'h0008);
    chk({15'h0000, pll_powered}, 16'h0000);
    restart(3'h1, 1'b1);
    count(64, n);
    chk(16'(gap), 16'h0008);
    chk(16'(pgap), 16'h0008);
    $display("test phases done");
    restart(3'h3, 1'b0);
    repeat (150) @(posedge ref_clk);
    chk({15'h0000, pll_powered}, 16'h0001);
    chk({15'h0000, osc_failed}, 16'h0000);
    irqs = 0;
    run <= 1'b0;
    repeat (150) @(posedge ref_clk);
    chk({15'h0000, osc_failed}, 16'h0001);
    chk(16'(irqs), 16'h0001);
    run <= 1'b1;
    repeat (40) @(posedge ref_clk);
    count(40, n);
    chk(n, 16'(40 / PLL_FREE_HALF));
    chk({15'h0000, osc_failed}, 16'h0001);
    restart(3'h1, 1'b0);
    chk({15'h0000, osc_failed}, 16'h0000);
    restart(3'h1, 1'b1);
    @(posedge ref_clk);
    run <= 1'b0;
    repeat (149) @(posedge ref_clk);
    chk({15'h0000, osc_failed}, 16'h0000);
    chk({15'h0000, pll_powered}, 16'h0000);
    run <= 1'b1;
    $display("test watchdog done");
    conclude();
  end
endmodule
